// file: rtl/irap_regs.svh
`ifndef IRAP_REGS_SVH
`define IRAP_REGS_SVH

// byte addresses inside the configuration space
`define IRAP_ADDR_PWM_ONE 8'hC0
`define IRAP_ADDR_PWM_TWO 8'hC1
`define IRAP_ADDR_PWM_THREE 8'hC2
`define IRAP_ADDR_SW_DIS 8'hF4
`define IRAP_ADDR_CTL_CODE 8'hE9
// last byte of the lockable lower region, bits 1535..0
`define IRAP_LOCK_LAST 8'hBF
// reset values and the value returned by a blocked read
`define IRAP_PWM_RESET 8'h65
`define IRAP_SW_DIS_RESET 8'h00
`define IRAP_READ_BLOCKED 8'h00
// field positions
`define IRAP_SW0_BIT 0
`define IRAP_SW1_BIT 1
`define IRAP_BLOCK_ZERO 3'h0
// bits per byte on the wire
`define IRAP_BYTE_BITS 4'h8
`define IRAP_BIT_ZERO 4'h0
`define IRAP_BIT_ONE 4'h1
`define IRAP_PTR_ONE 11'h001

`endif

// file: rtl/irap_pkg.sv
package irap_pkg;

	typedef enum logic [3:0] {
		IRAP_IDLE = 4'h0,
		IRAP_CTRL = 4'h1,
		IRAP_ACK_CTRL = 4'h2,
		IRAP_WADDR = 4'h3,
		IRAP_ACK_WADDR = 4'h4,
		IRAP_WDATA = 4'h5,
		IRAP_ACK_WDATA = 4'h6,
		IRAP_RDATA = 4'h7,
		IRAP_RMACK = 4'h8
	} irap_state_t;

	typedef enum logic [2:0] {
		IRAP_UNLOCKED = 3'h0,
		IRAP_LOCK_RD_LOW = 3'h1,
		IRAP_LOCK_WR_LOW = 3'h2,
		IRAP_LOCK_WR_ALL = 3'h3,
		IRAP_LOCK_RW_LOW = 3'h4,
		IRAP_LOCK_RD_LOW_WR_ALL = 3'h5
	} irap_lock_t;

endpackage : irap_pkg

// file: rtl/irap_mem.sv
module irap_mem #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	input wire logic clk_in,
	input wire logic wr_en_in,
	input wire logic [AW-1:0] wr_addr_in,
	input wire logic [DW-1:0] wr_data_in,
	input wire logic [AW-1:0] rd_addr_in,
	output logic [DW-1:0] rd_data_out
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk_in)
	begin
		if (wr_en_in)
		begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	// registered read port
	always_ff @(posedge clk_in)
	begin
		rd_data_out <= mem[rd_addr_in];
	end

endmodule : irap_mem

// file: rtl/irap_top.sv
`include "irap_regs.svh"

module irap_top #(
	parameter logic [3:0] CTRL_CODE_DEFAULT = 4'h8,
	parameter irap_pkg::irap_lock_t LOCK_OPTION = irap_pkg::IRAP_UNLOCKED
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	output logic [7:0] pwm_duty_led_one_out,
	output logic [7:0] pwm_duty_led_two_out,
	output logic [7:0] pwm_duty_led_three_out,
	output logic regulator_output_zero_disable_out,
	output logic regulator_output_one_disable_out
);

	////////////////////////////////////////////////////////////////////////////
	// lock decoding

	function automatic logic is_low(input logic [10:0] a);
		is_low = (a[10:8] == `IRAP_BLOCK_ZERO) && (a[7:0] <= `IRAP_LOCK_LAST);
	endfunction : is_low

	function automatic logic rd_blocked(input irap_pkg::irap_lock_t o, input logic [10:0] a);
		rd_blocked = is_low(a) && (o == irap_pkg::IRAP_LOCK_RD_LOW ||
			o == irap_pkg::IRAP_LOCK_RW_LOW || o == irap_pkg::IRAP_LOCK_RD_LOW_WR_ALL);
	endfunction : rd_blocked

	function automatic logic wr_blocked(input irap_pkg::irap_lock_t o, input logic [10:0] a);
		wr_blocked = (o == irap_pkg::IRAP_LOCK_WR_ALL) ||
			(o == irap_pkg::IRAP_LOCK_RD_LOW_WR_ALL) ||
			(is_low(a) && (o == irap_pkg::IRAP_LOCK_WR_LOW ||
			o == irap_pkg::IRAP_LOCK_RW_LOW));
	endfunction : wr_blocked

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and bus events

	logic scl_m, scl_s, scl_d;
	logic sda_m, sda_s, sda_d;

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			scl_m <= 1'h1;
			scl_s <= 1'h1;
			scl_d <= 1'h1;
			sda_m <= 1'h1;
			sda_s <= 1'h1;
			sda_d <= 1'h1;
		end
		else
		begin
			scl_m <= scl_in;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= sda_in;
			sda_s <= sda_m;
			sda_d <= sda_s;
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;

	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign bus_start = scl_s && scl_d && sda_d && !sda_s;
	assign bus_stop = scl_s && scl_d && !sda_d && sda_s;

	////////////////////////////////////////////////////////////////////////////
	// protocol state

	irap_pkg::irap_state_t st;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [2:0] blk;
	logic rw;
	logic drive_low;
	logic [10:0] ptr;
	logic [7:0] ctl_cfg;
	logic [7:0] rd_val;
	logic [7:0] mem_rd;
	logic byte_done, wr_fire, mem_we;

	assign byte_done = scl_fall && (bit_cnt == `IRAP_BYTE_BITS);
	assign wr_fire = byte_done && (st == irap_pkg::IRAP_WDATA);

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			st <= irap_pkg::IRAP_IDLE;
			bit_cnt <= `IRAP_BIT_ZERO;
			shreg <= 8'h00;
			blk <= 3'h0;
			rw <= 1'h0;
			drive_low <= 1'h0;
		end
		else if (bus_start)
		begin
			// repeated start drops any write in progress, pointer untouched
			st <= irap_pkg::IRAP_CTRL;
			bit_cnt <= `IRAP_BIT_ZERO;
			drive_low <= 1'h0;
		end
		else if (bus_stop)
		begin
			st <= irap_pkg::IRAP_IDLE;
			drive_low <= 1'h0;
		end
		else
		begin
			unique case (st)
				irap_pkg::IRAP_IDLE:
				begin
					drive_low <= 1'h0;
				end
				irap_pkg::IRAP_CTRL, irap_pkg::IRAP_WADDR, irap_pkg::IRAP_WDATA:
				begin
					if (scl_rise)
					begin
						shreg <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + `IRAP_BIT_ONE;
					end
					else if (byte_done)
					begin
						bit_cnt <= `IRAP_BIT_ZERO;
						if (st == irap_pkg::IRAP_CTRL)
						begin
							if (shreg[7:4] == ctl_cfg[3:0])
							begin
								blk <= shreg[3:1];
								rw <= shreg[0];
								drive_low <= 1'h1;
								st <= irap_pkg::IRAP_ACK_CTRL;
							end
							else
							begin
								st <= irap_pkg::IRAP_IDLE;
							end
						end
						else if (st == irap_pkg::IRAP_WADDR)
						begin
							drive_low <= 1'h1;
							st <= irap_pkg::IRAP_ACK_WADDR;
						end
						else
						begin
							drive_low <= 1'h1;
							st <= irap_pkg::IRAP_ACK_WDATA;
						end
					end
				end
				irap_pkg::IRAP_ACK_CTRL:
				begin
					if (scl_fall)
					begin
						if (rw)
						begin
							// first data bit goes out as the acknowledge ends
							shreg <= {rd_val[6:0], 1'h0};
							drive_low <= !rd_val[7];
							st <= irap_pkg::IRAP_RDATA;
						end
						else
						begin
							drive_low <= 1'h0;
							st <= irap_pkg::IRAP_WADDR;
						end
					end
				end
				irap_pkg::IRAP_ACK_WADDR, irap_pkg::IRAP_ACK_WDATA:
				begin
					if (scl_fall)
					begin
						drive_low <= 1'h0;
						st <= irap_pkg::IRAP_WDATA;
					end
				end
				irap_pkg::IRAP_RDATA:
				begin
					if (scl_rise)
					begin
						bit_cnt <= bit_cnt + `IRAP_BIT_ONE;
					end
					else if (byte_done)
					begin
						bit_cnt <= `IRAP_BIT_ZERO;
						drive_low <= 1'h0;
						st <= irap_pkg::IRAP_RMACK;
					end
					else if (scl_fall)
					begin
						drive_low <= !shreg[7];
						shreg <= {shreg[6:0], 1'h0};
					end
				end
				irap_pkg::IRAP_RMACK:
				begin
					if (scl_rise)
					begin
						rw <= !sda_s;
					end
					else if (scl_fall)
					begin
						if (rw)
						begin
							shreg <= {rd_val[6:0], 1'h0};
							drive_low <= !rd_val[7];
							st <= irap_pkg::IRAP_RDATA;
						end
						else
						begin
							st <= irap_pkg::IRAP_IDLE;
						end
					end
				end
				default:
				begin
					st <= irap_pkg::IRAP_IDLE;
					drive_low <= 1'h0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// address pointer

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			ptr <= 11'h000;
		end
		else if (byte_done && st == irap_pkg::IRAP_WADDR)
		begin
			ptr <= {blk, shreg};
		end
		else if (scl_fall && (st == irap_pkg::IRAP_ACK_WDATA || byte_done &&
			st == irap_pkg::IRAP_RDATA))
		begin
			ptr <= ptr + `IRAP_PTR_ONE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers

	logic wr_ok;

	assign wr_ok = wr_fire && !wr_blocked(LOCK_OPTION, ptr) && (ptr[10:8] == `IRAP_BLOCK_ZERO);

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			pwm_duty_led_one_out <= `IRAP_PWM_RESET;
			pwm_duty_led_two_out <= `IRAP_PWM_RESET;
			pwm_duty_led_three_out <= `IRAP_PWM_RESET;
			ctl_cfg <= {4'h0, CTRL_CODE_DEFAULT};
		end
		else if (wr_ok)
		begin
			unique case (ptr[7:0])
				`IRAP_ADDR_PWM_ONE: pwm_duty_led_one_out <= shreg;
				`IRAP_ADDR_PWM_TWO: pwm_duty_led_two_out <= shreg;
				`IRAP_ADDR_PWM_THREE: pwm_duty_led_three_out <= shreg;
				`IRAP_ADDR_CTL_CODE: ctl_cfg <= shreg;
				default: ctl_cfg <= ctl_cfg;
			endcase
		end
	end

	logic [7:0] sw_dis;

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			sw_dis <= `IRAP_SW_DIS_RESET;
		end
		else if (wr_ok && ptr[7:0] == `IRAP_ADDR_SW_DIS)
		begin
			sw_dis <= shreg;
		end
	end

	assign regulator_output_zero_disable_out = sw_dis[`IRAP_SW0_BIT];
	assign regulator_output_one_disable_out = sw_dis[`IRAP_SW1_BIT];

	assign mem_we = wr_ok;

	irap_mem #(
		.AW(8),
		.DW(8)
	) u_mem (
		.clk_in(core_clk_in),
		.wr_en_in(mem_we),
		.wr_addr_in(ptr[7:0]),
		.wr_data_in(shreg),
		.rd_addr_in(ptr[7:0]),
		.rd_data_out(mem_rd)
	);

	always_comb
	begin
		if (ptr[10:8] != `IRAP_BLOCK_ZERO || rd_blocked(LOCK_OPTION, ptr))
		begin
			rd_val = `IRAP_READ_BLOCKED;
		end
		else
		begin
			unique case (ptr[7:0])
				`IRAP_ADDR_PWM_ONE: rd_val = pwm_duty_led_one_out;
				`IRAP_ADDR_PWM_TWO: rd_val = pwm_duty_led_two_out;
				`IRAP_ADDR_PWM_THREE: rd_val = pwm_duty_led_three_out;
				`IRAP_ADDR_SW_DIS: rd_val = sw_dis;
				`IRAP_ADDR_CTL_CODE: rd_val = ctl_cfg;
				default: rd_val = mem_rd;
			endcase
		end
	end

	// open drain: only ever pulls low
	assign sda_out = 1'h0;
	assign sda_oe_out = drive_low;

endmodule : irap_top

// file: bench/irap_master.sv
module irap_master (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out = 1'b1,
	output logic sda_out = 1'b1
);
	timeunit 1ns;
	timeprecision 100ps;
	// third of a bit, 100 ns
	task automatic hp;
		repeat (20) @(negedge clk_in);
	endtask : hp
	// start and repeated start alike
	task automatic start;
		sda_out = 1'b1;
		hp();
		scl_out = 1'b1;
		hp();
		sda_out = 1'b0;
		hp();
		scl_out = 1'b0;
		hp();
	endtask : start
	task automatic stop;
		sda_out = 1'b0;
		hp();
		scl_out = 1'b1;
		hp();
		sda_out = 1'b1;
		hp();
	endtask : stop
	// nine bits msb first, a one releases the pulled-up wire
	task automatic xb(input logic [8:0] o, output logic [8:0] i);
		for (int k = 8; k >= 0; k--)
		begin
			sda_out = o[k];
			hp();
			scl_out = 1'b1;
			hp();
			i[k] = sda_in;
			scl_out = 1'b0;
			hp();
		end
	endtask : xb
endmodule : irap_master

// file: bench/irap_assertions.sv
module irap_assertions (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic [7:0] pwm_duty_led_one_out,
	input wire logic [7:0] pwm_duty_led_two_out,
	input wire logic [7:0] pwm_duty_led_three_out,
	input wire logic regulator_output_zero_disable_out,
	input wire logic regulator_output_one_disable_out
);
	timeunit 1ns;
	timeprecision 100ps;
	wire logic [25:0] regs = {pwm_duty_led_one_out, pwm_duty_led_two_out,
		pwm_duty_led_three_out, regulator_output_one_disable_out,
		regulator_output_zero_disable_out};
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	a_pwm_reset_value: assert property ($fell(sys_rst_in) |-> regs[25:2] == 24'h656565)
		else $error("duty reset");
	a_sw_reset_value: assert property ($fell(sys_rst_in) |-> regs[1:0] == 2'h0)
		else $error("switch reset");
	a_drive_low_only: assert property (sda_oe_out |-> !sda_out)
		else $error("sda driven high");
	a_ack_rise_low: assert property ($rose(sda_oe_out) |-> !scl_in && !$past(scl_in, 2))
		else $error("oe rose in scl high");
	a_ack_fall_low: assert property ($fell(sda_oe_out) |-> !scl_in)
		else $error("oe fell in scl high");
	a_commit_at_ack: assert property ($changed(regs) |-> sda_oe_out && !scl_in)
		else $error("register moved off ack");
	a_oe_still_high: assert property ($rose(scl_in) |=> $stable(sda_oe_out) [*4])
		else $error("oe moved in scl high");
	a_oe_settles: assert property ($fell(scl_in) |-> ##[1:6] $stable(sda_oe_out) [*8])
		else $error("oe unsettled");
	cover property ($rose(sda_oe_out));
	cover property ($changed(pwm_duty_led_three_out));
	cover property ($rose(regulator_output_one_disable_out));
endmodule : irap_assertions
////////////////////////////////////////
bind irap_top irap_assertions u_chk (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
	.pwm_duty_led_one_out(pwm_duty_led_one_out), .pwm_duty_led_two_out(pwm_duty_led_two_out),
	.pwm_duty_led_three_out(pwm_duty_led_three_out),
	.regulator_output_zero_disable_out(regulator_output_zero_disable_out),
	.regulator_output_one_disable_out(regulator_output_one_disable_out));

// file: bench/i2c_register_access_port_test.sv
module i2c_register_access_port_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [8:0] seen;
	logic [8:0] exp_q [$];
	logic [31:0] rnd = 32'hD15D333A;
	logic [7:0] v [3];
	int err_count = 0;
	int check_count = 0;
	event got;
	wire logic scl;
	wire logic sda_m;
	wire logic oe;
	wire logic d0;
	wire logic d1;
	wire logic [2:0][7:0] pwm;
	wire logic so;
	wire logic lk_oe;
	wire logic lk_so;
	wire logic [7:0] lk_pwm;
	wire logic [1:0] lk_dis;
	// pulled-up wire: a target sets the level only while its enable is high
	wire logic sda = sda_m & (!oe | so) & (!lk_oe | lk_so);
	always #2.5 core_clk_in = ~core_clk_in;
	irap_top u_dut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl),
		.sda_in(sda), .sda_out(so), .sda_oe_out(oe), .pwm_duty_led_one_out(pwm[0]),
		.pwm_duty_led_two_out(pwm[1]), .pwm_duty_led_three_out(pwm[2]),
		.regulator_output_zero_disable_out(d0), .regulator_output_one_disable_out(d1));
	// second target on the same wires: other code, low reads and all writes locked
	irap_top #(
		.CTRL_CODE_DEFAULT(4'h9),
		.LOCK_OPTION(irap_pkg::IRAP_LOCK_RD_LOW_WR_ALL)
	) u_dut_lock (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl),
		.sda_in(sda), .sda_out(lk_so), .sda_oe_out(lk_oe), .pwm_duty_led_one_out(lk_pwm),
		.pwm_duty_led_two_out(), .pwm_duty_led_three_out(),
		.regulator_output_zero_disable_out(lk_dis[0]),
		.regulator_output_one_disable_out(lk_dis[1]));
	irap_master u_mst (.clk_in(core_clk_in), .sda_in(sda), .scl_out(scl), .sda_out(sda_m));
	////////////////////////////////////////
	task automatic check(input logic [8:0] g, input logic [8:0] e);
		check_count++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask : check
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic summarize;
		if (err_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	// one byte plus ack slot; the wire pattern expected is queued for the watcher
	task automatic xfer(input logic [8:0] o, input logic [8:0] e);
		logic [8:0] r;
		exp_q.push_back(e);
		u_mst.xb(o, r);
		seen = r;
		->got;
	endtask : xfer
	task automatic tx(input logic [7:0] b, input logic nak);
		xfer({b, 1'b1}, {b, nak});
	endtask : tx
	task automatic rx(input logic [7:0] d, input logic mack);
		xfer({8'hFF, mack}, {d, mack});
	endtask : rx
	initial
		forever
		begin
			@(got);
			check(seen, exp_q.pop_front());
		end
	initial
	begin
		#300000;
		err_count++;
		summarize();
	end
	////////////////////////////////////////
	initial
	begin
		repeat (10) @(negedge core_clk_in);
		sys_rst_in = 1'b0;
		repeat (4) @(negedge core_clk_in);
		for (int i = 0; i < 3; i++)
			check({1'b0, pwm[i]}, 9'h065);
		check({7'h0, d1, d0}, 9'h000);
		for (int i = 0; i < 3; i++)
		begin
			rnd = lfsr_next(rnd);
			v[i] = rnd[7:0];
			u_mst.start();
			tx(8'h80, 1'b0);
			tx(8'(8'hC0 + i), 1'b0);
			tx(v[i], 1'b0);
			check({1'b0, pwm[i]}, {1'b0, v[i]});
			u_mst.stop();
		end
		for (int k = 1; k < 3; k++)
		begin
			u_mst.start();
			tx(8'h80, 1'b0);
			tx(8'hF4, 1'b0);
			tx(8'(k), 1'b0);
			u_mst.stop();
			check({7'h0, d1, d0}, 9'(k));
		end
		u_mst.start();
		tx(8'h82, 1'b0);
		tx(8'hC0, 1'b0);
		tx(~v[0], 1'b0);
		u_mst.stop();
		check({1'b0, pwm[0]}, {1'b0, v[0]});
		u_mst.start();
		tx(8'h30, 1'b1);
		tx(8'hC1, 1'b1);
		tx(~v[1], 1'b1);
		u_mst.stop();
		check({1'b0, pwm[1]}, {1'b0, v[1]});
		u_mst.start();
		tx(8'h80, 1'b0);
		tx(8'hC0, 1'b0);
		u_mst.start();
		tx(8'h81, 1'b0);
		rx(v[0], 1'b0);
		rx(v[1], 1'b1);
		u_mst.stop();
		u_mst.start();
		tx(8'h81, 1'b0);
		rx(v[2], 1'b1);
		u_mst.stop();
		// locked target: writes acknowledged but dropped
		u_mst.start();
		tx(8'h90, 1'b0);
		tx(8'hC0, 1'b0);
		tx(~v[0], 1'b0);
		u_mst.stop();
		check({1'b0, lk_pwm}, 9'h065);
		u_mst.start();
		tx(8'h90, 1'b0);
		tx(8'hF4, 1'b0);
		tx(8'h03, 1'b0);
		u_mst.stop();
		check({7'h0, lk_dis}, 9'h000);
		// last low byte reads as zero, first control byte after it reads through
		u_mst.start();
		tx(8'h90, 1'b0);
		tx(8'hBF, 1'b0);
		u_mst.start();
		tx(8'h91, 1'b0);
		rx(8'h00, 1'b0);
		rx(8'h65, 1'b1);
		u_mst.stop();
		summarize();
	end
endmodule : i2c_register_access_port_test
